// ==== core/delay_if.sv ====
// delay_if: request and fire strobe between the block and a delay timer
// assumes both ends sit on the same system clock
`timescale 1ns/10ps
interface delay_if;
  logic req;
  logic fire;
  modport timer (input req, output fire);
  modport user (output req, input fire);
endinterface : delay_if

// ==== core/reset_delay_timer.sv ====
// reset_delay_timer: fires after a request has stood for the guard delay, and again each guard delay while it stands
// assumes req comes from logic on the same clock; en low freezes the count
`timescale 1ns/10ps
module reset_delay_timer import reset_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // request and fire
  delay_if.timer dl
);
  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;
  logic fire_q;
  logic fire_d;
  wire logic at_end = (cnt_q == DLY_W'(GUARD_DELAY_CYC - 1));

  // count while requested, restart when the request goes away
  assign cnt_d = (!dl.req || at_end) ? '0 : cnt_q + DLY_W'(1);
  assign fire_d = dl.req && at_end;
  assign dl.fire = fire_q;

  // count and fire registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      fire_q <= 1'b0;
    end else if (en) begin
      cnt_q <= cnt_d;
      fire_q <= fire_d;
    end
  end
endmodule : reset_delay_timer

// ==== core/reset_pkg.sv ====
// reset_pkg: shared constants for the reset-cause block
// assumes a 20 MHz system clock and a 32-bit classic wishbone slave port
package reset_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int GUARD_DELAY_NS = 1000; // guard_reset_delay, plain default
  localparam int GUARD_DELAY_CYC = (GUARD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 8;
  // bus geometry
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CODE_W = 8;
  localparam int FLAG_W = 4;
  // register byte offsets
  localparam logic [ADR_W-1:0] OFF_FLAGS = 8'h00; // reset_cause_flags
  localparam logic [ADR_W-1:0] OFF_GUARD = 8'h04; // reset_guard_word
  localparam logic [ADR_W-1:0] OFF_VSEL = 8'h08; // brownout_voltage_select
  localparam logic [ADR_W-1:0] OFF_STATUS = 8'h0C; // timeout flag and mode
  // flag bit positions in reset_cause_flags
  localparam int FLG_WCFG = 0;
  localparam int FLG_VSEL = 1;
  localparam int FLG_BROWN = 2;
  localparam int FLG_GUARD = 3;
  // status register bit positions
  localparam int STS_TIMEOUT = 0;
  localparam int STS_LOWPWR = 1;
  // reset values and legal codes
  localparam logic [FLAG_W-1:0] FLAGS_POR = 4'h0;
  localparam logic [CODE_W-1:0] CODE_POR = 8'h55;
  localparam logic [CODE_W-1:0] GUARD_ALT = 8'hAA;
  localparam logic [CODE_W-1:0] VSEL_2V10 = 8'h55;
  localparam logic [CODE_W-1:0] VSEL_2V55 = 8'h33;
  localparam logic [CODE_W-1:0] VSEL_3V15 = 8'h99;
  localparam logic [CODE_W-1:0] VSEL_3V80 = 8'hAA;

  // guard word holds one of its two no-operation codes
  function automatic logic guard_ok(input logic [CODE_W-1:0] c);
    guard_ok = (c == CODE_POR) || (c == GUARD_ALT);
  endfunction : guard_ok

  // voltage select holds one of its four defined codes
  function automatic logic vsel_ok(input logic [CODE_W-1:0] c);
    vsel_ok = (c == VSEL_2V10) || (c == VSEL_2V55) || (c == VSEL_3V15) || (c == VSEL_3V80);
  endfunction : vsel_ok
endpackage : reset_pkg

// ==== core/reset_source_flags.sv ====
// reset_source_flags: reset-cause flags, guard word and voltage select checks
// assumes a classic wishbone master and reset sources on MCLK except BROWNOUT_DET
`timescale 1ns/10ps
module reset_source_flags import reset_pkg::*; (
  // clock, reset, enable
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DAT_W-1:0] WB_DAT_I,
  output logic [DAT_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  // reset sources
  input wire logic BROWNOUT_DET,
  input wire logic WDT_TIMEOUT,
  input wire logic WDT_CFG_BAD,
  input wire logic USB_RST_REQ,
  input wire logic LOW_POWER_MODE,
  // reset effects
  output logic CHIP_RST,
  output logic PC_SP_CLR,
  output logic TIMEOUT_FLAG
);
  // state
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [CODE_W-1:0] guard_q;
  logic [CODE_W-1:0] guard_d;
  logic [CODE_W-1:0] vsel_q;
  logic [CODE_W-1:0] vsel_d;
  logic timeout_q;
  logic timeout_d;
  logic ack_q;
  logic [DAT_W-1:0] rdat_q;
  logic [DAT_W-1:0] rdat_d;
  logic chip_rst_q;
  logic chip_rst_d;
  logic pcsp_q;
  logic pcsp_d;
  logic brown_s1_q;
  logic brown_s2_q;
  logic brown_s3_q;
  logic usb_q;

  // delay timers for guard word and voltage select
  delay_if guard_dl ();
  delay_if vsel_dl ();

  reset_delay_timer u_guard_tmr (
    .clk(MCLK),
    .rst_n(ARST_N),
    .en(CLK_EN),
    .dl(guard_dl.timer)
  );

  reset_delay_timer u_vsel_tmr (
    .clk(MCLK),
    .rst_n(ARST_N),
    .en(CLK_EN),
    .dl(vsel_dl.timer)
  );

  // bus access decode
  wire logic bus_acc = WB_CYC_I && WB_STB_I && !ack_q;
  wire logic wr_lane = bus_acc && WB_WE_I && WB_SEL_I[0];
  wire logic sel_flags = (WB_ADR_I == OFF_FLAGS);
  wire logic sel_guard = (WB_ADR_I == OFF_GUARD);
  wire logic sel_vsel = (WB_ADR_I == OFF_VSEL);
  wire logic sel_status = (WB_ADR_I == OFF_STATUS);
  wire logic wr_flags = wr_lane && sel_flags;
  wire logic wr_guard = wr_lane && sel_guard;
  wire logic wr_vsel = wr_lane && sel_vsel;
  wire logic wr_status = wr_lane && sel_status;

  // event detection, brownout pin read only past the second stage
  wire logic brown_rise = brown_s2_q && !brown_s3_q;
  wire logic usb_rise = USB_RST_REQ && !usb_q;
  wire logic wdt_run = WDT_TIMEOUT && !LOW_POWER_MODE;
  wire logic wdt_sleep = WDT_TIMEOUT && LOW_POWER_MODE;
  wire logic guard_bad = !guard_ok(guard_q);
  wire logic vsel_bad = !vsel_ok(vsel_q);

  // delay requests
  assign guard_dl.req = guard_bad;
  assign vsel_dl.req = vsel_bad;

  // flag set vector in register bit order
  wire logic [FLAG_W-1:0] flag_set = {guard_dl.fire, brown_rise, vsel_bad, WDT_CFG_BAD};
  // a written zero clears, a written one has no effect
  wire logic [FLAG_W-1:0] flag_clr = wr_flags ? ~WB_DAT_I[FLAG_W-1:0] : '0;

  // next flags, a set in the same cycle beats the clear
  assign flags_d = flag_set | (flags_q & ~flag_clr);

  // full chip reset sources
  assign chip_rst_d = guard_dl.fire || vsel_dl.fire || WDT_CFG_BAD || usb_rise
                      || brown_rise || wdt_run;
  // warm reset in sleep or idle, only when no full reset is due
  assign pcsp_d = wdt_sleep && !chip_rst_d;

  // control words reload their power-on code on any full reset
  assign guard_d = chip_rst_d ? CODE_POR : (wr_guard ? WB_DAT_I[CODE_W-1:0] : guard_q);
  assign vsel_d = chip_rst_d ? CODE_POR : (wr_vsel ? WB_DAT_I[CODE_W-1:0] : vsel_q);

  // timeout flag set by any watchdog timeout, written zero clears
  assign timeout_d = WDT_TIMEOUT
                     || (timeout_q && !(wr_status && !WB_DAT_I[STS_TIMEOUT]));

  // read data mux, unmapped offsets read zero
  wire logic [DAT_W-1:0] rd_flags = {{(DAT_W-FLAG_W){1'b0}}, flags_q};
  wire logic [DAT_W-1:0] rd_guard = {{(DAT_W-CODE_W){1'b0}}, guard_q};
  wire logic [DAT_W-1:0] rd_vsel = {{(DAT_W-CODE_W){1'b0}}, vsel_q};
  wire logic [DAT_W-1:0] rd_status = {{(DAT_W-2){1'b0}}, LOW_POWER_MODE, timeout_q};
  assign rdat_d = sel_flags ? rd_flags :
                  sel_guard ? rd_guard :
                  sel_vsel ? rd_vsel :
                  sel_status ? rd_status : '0;

  // synchroniser for the brownout detector pin
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      brown_s1_q <= 1'b0;
      brown_s2_q <= 1'b0;
      brown_s3_q <= 1'b0;
    end else if (CLK_EN) begin
      brown_s1_q <= BROWNOUT_DET;
      brown_s2_q <= brown_s1_q;
      brown_s3_q <= brown_s2_q;
    end
  end

  // flags and control words
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_q <= FLAGS_POR;
      guard_q <= CODE_POR;
      vsel_q <= CODE_POR;
      timeout_q <= 1'b0;
      usb_q <= 1'b0;
    end else if (CLK_EN) begin
      flags_q <= flags_d;
      guard_q <= guard_d;
      vsel_q <= vsel_d;
      timeout_q <= timeout_d;
      usb_q <= USB_RST_REQ;
    end
  end

  // reset effect outputs
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      chip_rst_q <= 1'b0;
      pcsp_q <= 1'b0;
    end else if (CLK_EN) begin
      chip_rst_q <= chip_rst_d;
      pcsp_q <= pcsp_d;
    end
  end

  // bus answer, one wait state, ack for exactly one cycle
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else if (CLK_EN) begin
      ack_q <= bus_acc;
      rdat_q <= bus_acc ? rdat_d : rdat_q;
    end
  end

  // outputs straight from flip-flops
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign CHIP_RST = chip_rst_q;
  assign PC_SP_CLR = pcsp_q;
  assign TIMEOUT_FLAG = timeout_q;

  // checks on the flag and reset behaviour
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  a_brown_set: assert property (CLK_EN && brown_rise |=> flags_q[FLG_BROWN])
    else $error("brownout event did not set its flag");

  a_brown_sticky: assert property (
    flags_q[FLG_BROWN] && !(CLK_EN && wr_flags && !WB_DAT_I[FLG_BROWN])
    |=> flags_q[FLG_BROWN])
    else $error("brownout flag dropped without a software clear");

  a_vsel_flag: assert property (CLK_EN && vsel_bad |=> flags_q[FLG_VSEL])
    else $error("bad voltage select did not set its flag");

  a_vsel_reset: assert property (
    CLK_EN && vsel_dl.fire |=> CHIP_RST && vsel_q == CODE_POR)
    else $error("bad voltage select did not reset the chip");

  a_wcfg_flag: assert property (
    CLK_EN && WDT_CFG_BAD |=> flags_q[FLG_WCFG] && CHIP_RST)
    else $error("bad watchdog setting not recorded");

  a_usb_reset: assert property (CLK_EN && usb_rise |=> CHIP_RST)
    else $error("usb request did not reset the chip");

  a_wdt_run: assert property (
    CLK_EN && wdt_run |=> CHIP_RST && TIMEOUT_FLAG && !PC_SP_CLR)
    else $error("run-mode timeout did not act as full reset");

  a_wdt_sleep: assert property (
    CLK_EN && wdt_sleep && !chip_rst_d |=> PC_SP_CLR && !CHIP_RST
    ##1 (!PC_SP_CLR || $past(wdt_sleep)))
    else $error("sleep timeout did not give a one-cycle warm clear");

  a_wdt_flag: assert property (CLK_EN && WDT_TIMEOUT |=> TIMEOUT_FLAG)
    else $error("watchdog timeout flag not set");

  a_flag_upper: assert property (
    CLK_EN && bus_acc && sel_flags && !WB_WE_I |=> WB_ACK_O && WB_DAT_O[7:4] == 4'h0)
    else $error("unused flag bits read nonzero");

  a_guard_reset: assert property (
    CLK_EN && guard_dl.fire |=> CHIP_RST && flags_q[FLG_GUARD] && guard_q == CODE_POR)
    else $error("guard word reset not recorded");

  a_guard_quiet: assert property (
    !guard_bad && !guard_dl.fire |=> !guard_dl.fire)
    else $error("guard timer fired on a valid guard word");

  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");

  c_brown_reset: cover property (CLK_EN && brown_rise ##1 CHIP_RST);
  c_guard_reset: cover property (CLK_EN && guard_dl.fire ##1 flags_q[FLG_GUARD]);
  c_sleep_warm: cover property (PC_SP_CLR && TIMEOUT_FLAG);
  c_flag_clear: cover property (flags_q[FLG_VSEL] ##1 !flags_q[FLG_VSEL]);
endmodule : reset_source_flags

// ==== dv/test_reset_source_flags.sv ====
// test_reset_source_flags: random and corner tests of the reset-cause block
// assumes the offsets, flag layout and guard delay of reset_pkg
`timescale 1ns/10ps
module test_reset_source_flags import reset_pkg::*;;
  logic mclk, arst_n, cyc, stb, we, ack, chip_rst, pcsp, tflag, lpm, pc_seen;
  logic [3:0] src;
  logic [ADR_W-1:0] adr;
  logic [DAT_W-1:0] wdat, dat_o, got;
  logic [7:0] codes [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
  int err_count, check_count, seed, first, i;

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  reset_source_flags reset_source_flags_i (.MCLK(mclk), .ARST_N(arst_n), .CLK_EN(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .BROWNOUT_DET(src[0]),
    .WDT_TIMEOUT(src[1]), .WDT_CFG_BAD(src[2]), .USB_RST_REQ(src[3]),
    .LOW_POWER_MODE(lpm), .CHIP_RST(chip_rst), .PC_SP_CLR(pcsp), .TIMEOUT_FLAG(tflag));

  // expected flag pattern for one bit
  function automatic logic [7:0] flag_bit(input int b);
    flag_bit = 8'h01 << b;
  endfunction : flag_bit

  // codes that leave the register without a reset
  function automatic logic legal(input logic [ADR_W-1:0] a, input logic [7:0] c);
    legal = (a == OFF_GUARD) ? (c inside {8'h55, 8'hAA}) : (c inside {8'h55, 8'h33, 8'h99, 8'hAA});
  endfunction : legal

  // compare and count
  task automatic chk(input logic [DAT_W-1:0] g, input logic [DAT_W-1:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= DAT_W'(d);
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    got = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) chk(DAT_W'(0), DAT_W'(1));
  endtask : wb

  task automatic rd(input logic [ADR_W-1:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(got, DAT_W'(e));
  endtask : rd

  // note first reset cycle and any warm clear within n cycles
  task automatic watch(input int n);
    first = -1;
    pc_seen = 1'b0;
    for (int k = 1; k <= n; k++) begin
      @(negedge mclk);
      if (chip_rst === 1'b1 && first < 0) first = k;
      if (pcsp === 1'b1) pc_seen = 1'b1;
    end
  endtask : watch

  // one reset-source event, then flags, sticky clear and timeout flag
  task automatic fire(input int s, input logic lp, input logic [7:0] ef, input logic er);
    @(posedge mclk);
    lpm <= lp;
    src <= 4'h1 << s;
    @(posedge mclk);
    src <= 4'h0;
    watch(8);
    chk(DAT_W'(first > 0 && first <= 5), DAT_W'(er));
    chk(DAT_W'(pc_seen), DAT_W'(s == 1 && lp));
    wb(1'b1, OFF_FLAGS, 8'hFF);
    rd(OFF_FLAGS, ef);
    chk(DAT_W'(tflag), DAT_W'(s == 1));
    rd(OFF_STATUS, {6'h00, lp, 1'(s == 1)});
    wb(1'b1, OFF_FLAGS, 8'h00);
    wb(1'b1, OFF_STATUS, 8'h00);
    rd(OFF_FLAGS, 8'h00);
  endtask : fire

  // write a code, expect delayed reset and reload when it is undefined
  task automatic code_test(input logic [ADR_W-1:0] a, input logic [7:0] c);
    logic ok;
    ok = legal(a, c);
    wb(1'b1, a, c);
    watch(GUARD_DELAY_CYC + 8);
    chk(DAT_W'(ok ? first < 0 : (first >= GUARD_DELAY_CYC - 3 && first <= GUARD_DELAY_CYC + 3)),
      DAT_W'(1));
    rd(a, ok ? c : 8'h55);
    rd(OFF_FLAGS, ok ? 8'h00 : flag_bit(a == OFF_GUARD ? FLG_GUARD : FLG_VSEL));
    wb(1'b1, OFF_FLAGS, 8'h00);
  endtask : code_test

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    seed = 91;
    err_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    {cyc, stb, we, lpm} = 4'h0;
    adr = '0;
    wdat = '0;
    src = 4'h0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFF_FLAGS, 8'h00);
    rd(OFF_GUARD, 8'h55);
    rd(OFF_VSEL, 8'h55);
    rd(8'h40, 8'h00);
    fire(0, 1'b0, flag_bit(FLG_BROWN), 1'b1);
    fire(2, 1'b0, flag_bit(FLG_WCFG), 1'b1);
    fire(3, 1'b0, 8'h00, 1'b1);
    fire(1, 1'b0, 8'h00, 1'b1);
    fire(1, 1'b1, 8'h00, 1'b0);
    for (i = 0; i < 8; i++) code_test(i[0] ? OFF_VSEL : OFF_GUARD, codes[i >> 1]);
    for (i = 0; i < 6; i++) code_test(i[0] ? OFF_VSEL : OFF_GUARD, 8'($random(seed)));
    tally_and_finish();
  end

  // hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule : test_reset_source_flags
